// ==== core/nibble_gpio_map.svh ====
// Address map, field positions and masks of the nibble port block.
`ifndef NIBBLE_GPIO_MAP_SVH
`define NIBBLE_GPIO_MAP_SVH

// Control-file address ranges.
`define CF_CTRL_TOP 7'h3f
`define CF_DM_TOP 7'h73
`define CF_SYS_BASE 7'h74
`define CF_CTRL_NIB 64
`define CF_NONE 4'h0

// Port registers in bank 0 of data memory.
`define PORT_A_ADDR 7'h70
`define PORT_B_ADDR 7'h71
`define PORT_BANK 1'b0
`define SYS_BANK 1'b0

// Implemented control nibbles.
`define CF_A_WDT 6'h03
`define CF_A_SIO 6'h0b
`define CF_A_PULLUP 6'h0c
`define CF_A_TM0 6'h11
`define CF_A_TM1 6'h12
`define CF_A_BTM 6'h13
`define CF_A_ADSEL 6'h1b
`define CF_A_CDIR 6'h1c
`define CF_A_ADC 6'h20
`define CF_A_ADCH 6'h22
`define CF_A_DDIR 6'h2b
`define CF_A_GDIR 6'h2c

// Writable bits of each implemented nibble.
`define CF_W_WDT 4'h9
`define CF_W_SIO 4'h9
`define CF_W_PULLUP 4'h3
`define CF_W_TMR 4'h4
`define CF_W_FULL 4'hf
`define CF_W_ADC 4'h1
`define CF_W_PAIR 4'h3

// Write-only action bits, which always read as zero.
`define CF_ACT_WDT 4'h9
`define CF_ACT_TMR 4'h4
`define CF_ACT_ADC 4'h1

// Bit positions.
`define WDT_CLEAR_BIT 3
`define WDT_ENABLE_BIT 0
`define TMR_RESET_BIT 2
`define CONV_START_BIT 0
`define PORT_A_BIT 0
`define PORT_B_BIT 1

`endif

// ==== core/nibble_gpio_pkg.sv ====
// Types shared by the nibble port block and its control nibbles.
package nibble_gpio_pkg;

    typedef logic [3:0] nibble_t;
    typedef logic [6:0] addr_t;
    typedef logic [63:0][3:0] cf_file_t;

    // One CPU access: a data-memory or a control-file instruction.
    typedef struct packed {
        logic rd;
        logic wr;
        logic rf;
        logic bank;
        addr_t addr;
        nibble_t wdata;
    } cpu_req_s;

    // Access forwarded to the data memory outside this block.
    typedef struct packed {
        logic rd;
        logic wr;
        logic bank;
        addr_t addr;
        nibble_t wdata;
    } mem_req_s;

    // One-cycle strobes raised by writes to action bits.
    typedef struct packed {
        logic watchdog_clear_bit;
        logic watchdog_enable_bit;
        logic timer_zero_reset_bit;
        logic timer_one_reset_bit;
        logic basic_timer_reset_bit;
        logic conversion_start_bit;
    } actions_s;

endpackage : nibble_gpio_pkg

// ==== core/control_nibble.sv ====
// One nibble of the control file with write, action and read-only masks.
`timescale 1ns/10ps
`default_nettype none

module control_nibble #(
    parameter logic [3:0] WMASK = 4'h0,
    parameter logic [3:0] AMASK = 4'h0,
    parameter logic [3:0] ROMASK = 4'h0
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_we,
    input wire nibble_gpio_pkg::nibble_t i_wdata,
    input wire nibble_gpio_pkg::nibble_t i_status,
    output nibble_gpio_pkg::nibble_t o_value,
    output nibble_gpio_pkg::nibble_t o_rdata,
    output nibble_gpio_pkg::nibble_t o_pulse
);
    import nibble_gpio_pkg::*;

    // Action bits are not stored, so they can never read back as one.
    wire nibble_t store_mask = WMASK & ~AMASK & ~ROMASK;
    wire nibble_t store_nxt;
    wire nibble_t pulse_nxt;
    nibble_t store_r;
    nibble_t pulse_r;

    assign store_nxt = i_we ? (i_wdata & store_mask) : store_r;
    assign pulse_nxt = i_we ? (i_wdata & AMASK) : 4'h0;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            store_r <= 4'h0;
            pulse_r <= 4'h0;
        end else begin
            store_r <= store_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign o_value = store_r;
    assign o_pulse = pulse_r;
    // Fixed bits and action bits read as zero.
    assign o_rdata = (store_r & store_mask) | (i_status & ROMASK);

endmodule // control_nibble

`default_nettype wire

// ==== core/nibble_gpio_ports.sv ====
// Two nibble GPIO ports with the control file that configures them.
//
// Operation
// - Control-file 00H-3FH selects control nibbles, any bank.
// - Control-file 40H-73H reaches selected-bank data memory.
// - Control-file 74H-7FH reaches system register, bank-independent.
// - Control nibbles reached only by control-file instructions.
// - Sixty-four control slots, implemented ones one nibble.
// - Unimplemented control slots read arbitrary; here zero.
// - Writes to unimplemented control slots change nothing.
// - Read-only nibbles ignore writes; others read/write.
// - Watchdog, timer-reset, conversion-start bits read zero.
// - Fixed bits inside nibbles read zero, ignore writes.
// - Port A: 4-bit latch at bank 0, 70H.
// - Port A direction: bit 0 of 2CH, 1=out.
// - Port A input mode reads pin levels.
// - Port A output mode drives latch, reads latch.
// - Bit 0 of 0CH enables port A pull-ups.
// - Reset: port A input, no pull-up, latch zero.
// - Port B: 4-bit latch at bank 0, 71H.
// - Port B direction: bit 1 of 2CH, 1=out.
// - Port B reads pins as input, latch as output.
// - Bit 1 of 0CH enables port B pull-ups.
// - Reset: port B input, no pull-up, latch zero.
`timescale 1ns/10ps
`default_nettype none
`include "nibble_gpio_map.svh"

module nibble_gpio_ports #(
    parameter nibble_gpio_pkg::cf_file_t RO_MASKS = '0
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire nibble_gpio_pkg::cpu_req_s i_req,
    input wire nibble_gpio_pkg::nibble_t i_mem_rdata,
    input wire nibble_gpio_pkg::cf_file_t i_cf_status,
    input wire nibble_gpio_pkg::nibble_t i_pa_pins,
    input wire nibble_gpio_pkg::nibble_t i_pb_pins,
    output nibble_gpio_pkg::nibble_t o_rdata,
    output logic o_rvalid,
    output nibble_gpio_pkg::mem_req_s o_mem_req,
    output nibble_gpio_pkg::nibble_t o_pa_out,
    output nibble_gpio_pkg::nibble_t o_pa_oe_n,
    output logic o_pa_pullup,
    output nibble_gpio_pkg::nibble_t o_pb_out,
    output nibble_gpio_pkg::nibble_t o_pb_oe_n,
    output logic o_pb_pullup,
    output nibble_gpio_pkg::cf_file_t o_cf_value,
    output nibble_gpio_pkg::actions_s o_actions
);
    import nibble_gpio_pkg::*;

    // Writable bits of each control nibble; zero marks an unused slot.
    function automatic nibble_t wmask_of(input logic [5:0] a);
        case (a)
            `CF_A_WDT: wmask_of = `CF_W_WDT;
            `CF_A_SIO: wmask_of = `CF_W_SIO;
            `CF_A_PULLUP: wmask_of = `CF_W_PULLUP;
            `CF_A_TM0: wmask_of = `CF_W_TMR;
            `CF_A_TM1: wmask_of = `CF_W_TMR;
            `CF_A_BTM: wmask_of = `CF_W_TMR;
            `CF_A_ADSEL: wmask_of = `CF_W_FULL;
            `CF_A_CDIR: wmask_of = `CF_W_FULL;
            `CF_A_ADC: wmask_of = `CF_W_ADC;
            `CF_A_ADCH: wmask_of = `CF_W_PAIR;
            `CF_A_DDIR: wmask_of = `CF_W_FULL;
            `CF_A_GDIR: wmask_of = `CF_W_PAIR;
            default: wmask_of = `CF_NONE;
        endcase
    endfunction

    // Action bits strobe a peripheral and are never stored.
    function automatic nibble_t amask_of(input logic [5:0] a);
        case (a)
            `CF_A_WDT: amask_of = `CF_ACT_WDT;
            `CF_A_TM0: amask_of = `CF_ACT_TMR;
            `CF_A_TM1: amask_of = `CF_ACT_TMR;
            `CF_A_BTM: amask_of = `CF_ACT_TMR;
            `CF_A_ADC: amask_of = `CF_ACT_ADC;
            default: amask_of = `CF_NONE;
        endcase
    endfunction

    // Request decode.
    wire logic req_wr = i_req.wr;
    // A request with both strobes set is taken as a write only.
    wire logic req_rd = i_req.rd & ~i_req.wr;
    wire logic req_any = req_wr | req_rd;

    // Only the control-file instructions see the control area; an
    // ordinary data-memory access to 00H-3FH goes to data memory.
    wire logic hit_ctrl = i_req.rf & (i_req.addr <= `CF_CTRL_TOP);
    wire logic hit_sys = (i_req.addr >= `CF_SYS_BASE);
    // The system register looks the same in every bank, so the bank
    // is forced before the access leaves the block.
    wire logic eff_bank = hit_sys ? `SYS_BANK : i_req.bank;
    wire logic in_port_bank = ~hit_ctrl & (eff_bank == `PORT_BANK);
    wire logic hit_pa = in_port_bank & (i_req.addr == `PORT_A_ADDR);
    wire logic hit_pb = in_port_bank & (i_req.addr == `PORT_B_ADDR);
    wire logic hit_ext = req_any & ~hit_ctrl & ~hit_pa & ~hit_pb;
    wire logic [5:0] cf_index = i_req.addr[5:0];

    // Control file: sixty-four slots, unused ones hold no state.
    cf_file_t cf_value;
    cf_file_t cf_rdata;
    cf_file_t cf_pulse;
    wire logic [`CF_CTRL_NIB-1:0] cf_we;

    genvar gi;
    generate
        for (gi = 0; gi < `CF_CTRL_NIB; gi = gi + 1) begin : g_cf
            // A write to an unused slot meets an all-zero mask and is lost.
            assign cf_we[gi] = req_wr & hit_ctrl & (cf_index == 6'(gi));
            control_nibble #(
                .WMASK(wmask_of(6'(gi))),
                .AMASK(amask_of(6'(gi))),
                .ROMASK(RO_MASKS[gi])
            ) u_nibble (
                .i_mclk(i_mclk),
                .i_rst(i_rst),
                .i_we(cf_we[gi]),
                .i_wdata(i_req.wdata),
                .i_status(i_cf_status[gi]),
                .o_value(cf_value[gi]),
                .o_rdata(cf_rdata[gi]),
                .o_pulse(cf_pulse[gi])
            );
        end
    endgenerate

    // Unused slots return zero rather than leaking another nibble.
    wire nibble_t ctrl_rdata = cf_rdata[cf_index];

    // Port configuration, straight from the control nibbles.
    wire logic pa_dir = cf_value[`CF_A_GDIR][`PORT_A_BIT];
    wire logic pb_dir = cf_value[`CF_A_GDIR][`PORT_B_BIT];

    // Output latches.
    nibble_t pa_latch_r;
    nibble_t pb_latch_r;
    // The latch is written in either direction so that switching to
    // output presents the value software prepared beforehand.
    wire nibble_t pa_latch_nxt = (req_wr & hit_pa) ? i_req.wdata : pa_latch_r;
    wire nibble_t pb_latch_nxt = (req_wr & hit_pb) ? i_req.wdata : pb_latch_r;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            pa_latch_r <= 4'h0;
            pb_latch_r <= 4'h0;
        end else begin
            pa_latch_r <= pa_latch_nxt;
            pb_latch_r <= pb_latch_nxt;
        end
    end

    // Port reads follow the direction: pins as input, latch as output.
    wire nibble_t pa_rdata = pa_dir ? pa_latch_r : i_pa_pins;
    wire nibble_t pb_rdata = pb_dir ? pb_latch_r : i_pb_pins;

    // Pin drivers. The enables follow the direction bit one clock late,
    // which keeps every pin output on its own flip-flop.
    nibble_t pa_oe_n_r;
    nibble_t pb_oe_n_r;
    wire nibble_t pa_oe_n_nxt = {4{~pa_dir}};
    wire nibble_t pb_oe_n_nxt = {4{~pb_dir}};

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            pa_oe_n_r <= 4'hf;
            pb_oe_n_r <= 4'hf;
        end else begin
            pa_oe_n_r <= pa_oe_n_nxt;
            pb_oe_n_r <= pb_oe_n_nxt;
        end
    end

    // Read data from the targets inside the block.
    wire nibble_t int_rdata = hit_ctrl ? ctrl_rdata :
                              hit_pa ? pa_rdata :
                              hit_pb ? pb_rdata : 4'h0;

    // Forwarded access to data memory and the system register.
    wire mem_req_s mem_req_nxt = hit_ext ?
        mem_req_s'{rd: req_rd, wr: req_wr, bank: eff_bank, addr: i_req.addr,
                   wdata: i_req.wdata} : '0;

    // Read pipeline. Every read answers two clocks after it is taken,
    // whether the nibble lives here or in data memory, so the CPU sees
    // one fixed latency and may issue a request every clock.
    logic rd_pend_r;
    logic rd_ext_r;
    nibble_t rd_int_r;
    mem_req_s mem_req_r;
    nibble_t rdata_r;
    logic rvalid_r;
    wire nibble_t rdata_nxt = rd_ext_r ? i_mem_rdata : rd_int_r;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rd_pend_r <= 1'b0;
            rd_ext_r <= 1'b0;
            rd_int_r <= 4'h0;
            mem_req_r <= '0;
        end else begin
            rd_pend_r <= req_rd;
            rd_ext_r <= req_rd & hit_ext;
            rd_int_r <= int_rdata;
            mem_req_r <= mem_req_nxt;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rdata_r <= 4'h0;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= rd_pend_r ? rdata_nxt : 4'h0;
            rvalid_r <= rd_pend_r;
        end
    end

    // Outputs, each taken from a flip-flop.
    assign o_rdata = rdata_r;
    assign o_rvalid = rvalid_r;
    assign o_mem_req = mem_req_r;
    assign o_pa_out = pa_latch_r;
    assign o_pb_out = pb_latch_r;
    assign o_pa_oe_n = pa_oe_n_r;
    assign o_pb_oe_n = pb_oe_n_r;
    assign o_pa_pullup = cf_value[`CF_A_PULLUP][`PORT_A_BIT];
    assign o_pb_pullup = cf_value[`CF_A_PULLUP][`PORT_B_BIT];
    assign o_cf_value = cf_value;

    // Action strobes last one clock after the write that raised them.
    assign o_actions.watchdog_clear_bit = cf_pulse[`CF_A_WDT][`WDT_CLEAR_BIT];
    assign o_actions.watchdog_enable_bit = cf_pulse[`CF_A_WDT][`WDT_ENABLE_BIT];
    assign o_actions.timer_zero_reset_bit = cf_pulse[`CF_A_TM0][`TMR_RESET_BIT];
    assign o_actions.timer_one_reset_bit = cf_pulse[`CF_A_TM1][`TMR_RESET_BIT];
    assign o_actions.basic_timer_reset_bit = cf_pulse[`CF_A_BTM][`TMR_RESET_BIT];
    assign o_actions.conversion_start_bit = cf_pulse[`CF_A_ADC][`CONV_START_BIT];

endmodule // nibble_gpio_ports

`default_nettype wire

// ==== dv/pin_side_model.sv ====
// External circuitry seen by one nibble port.
`timescale 1ns/10ps
`default_nettype none
module pin_side_model (
    input wire logic i_mclk,
    input wire nibble_gpio_pkg::nibble_t i_out,
    input wire nibble_gpio_pkg::nibble_t i_oe_n,
    input wire logic i_pullup,
    input wire logic i_ext_en,
    input wire nibble_gpio_pkg::nibble_t i_ext,
    output nibble_gpio_pkg::nibble_t o_pins
);
    import nibble_gpio_pkg::*;
    // A floating pin toggles so that a stale value can never pass for a match.
    nibble_t float_r = 4'h5;
    always @(posedge i_mclk) float_r <= ~float_r;
    assign o_pins = (~i_oe_n & i_out) | (i_oe_n & (i_ext_en ? i_ext :
        (i_pullup ? 4'hf : float_r)));
endmodule // pin_side_model
`default_nettype wire

// ==== dv/nibble_gpio_ports_sva.sv ====
// Concurrent checks on the nibble port block's ports.
`timescale 1ns/10ps
`default_nettype none
module nibble_gpio_ports_sva (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire nibble_gpio_pkg::cpu_req_s i_req,
    input wire nibble_gpio_pkg::nibble_t i_pa_pins,
    input wire nibble_gpio_pkg::nibble_t o_rdata,
    input wire logic o_rvalid,
    input wire nibble_gpio_pkg::mem_req_s o_mem_req,
    input wire nibble_gpio_pkg::nibble_t o_pa_out,
    input wire nibble_gpio_pkg::nibble_t o_pa_oe_n,
    input wire nibble_gpio_pkg::nibble_t o_pb_oe_n,
    input wire logic o_pa_pullup,
    input wire logic o_pb_pullup,
    input wire nibble_gpio_pkg::cf_file_t o_cf_value,
    input wire nibble_gpio_pkg::actions_s o_actions
);
    import nibble_gpio_pkg::*;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    wire logic rd_c = i_req.rd && !i_req.wr;
    wire logic wr_c = i_req.wr;
    wire logic ctl_c = i_req.rf && i_req.addr <= 7'h3f;
    wire logic pa_c = !i_req.bank && i_req.addr == 7'h70;
    sequence s_rd_pa;
        rd_c && pa_c;
    endsequence
    sequence s_wr_pull;
        wr_c && ctl_c && i_req.addr == 7'h0c ##1 !wr_c;
    endsequence
    a_read_latency: assert property (rd_c |-> ##2 o_rvalid)
        else $error("read answer missing");
    a_pa_in_read: assert property (s_rd_pa ##0 !o_cf_value[6'h2c][0]
        |-> ##2 o_rdata == $past(i_pa_pins, 2)) else $error("pin read bad");
    a_pa_out_read: assert property (s_rd_pa ##0 o_cf_value[6'h2c][0]
        |-> ##2 o_rdata == $past(o_pa_out, 2)) else $error("latch read bad");
    a_oe_lag: assert property (!$past(i_rst) |->
        o_pa_oe_n == {4{!$past(o_cf_value[6'h2c][0])}} &&
        o_pb_oe_n == {4{!$past(o_cf_value[6'h2c][1])}}) else $error("oe bad");
    a_pullup_set: assert property (s_wr_pull |-> ##1
        {o_pb_pullup, o_pa_pullup} == $past(i_req.wdata[1:0], 2))
        else $error("pull-up bad");
    a_ctrl_local: assert property ((rd_c || wr_c) && ctl_c |=>
        !o_mem_req.rd && !o_mem_req.wr) else $error("control forwarded");
    a_fwd_bank: assert property (rd_c && i_req.rf && i_req.bank &&
        i_req.addr inside {[7'h40:7'h73]} |=> o_mem_req.rd && o_mem_req.bank)
        else $error("bank not kept");
    a_sys_bank0: assert property (rd_c && i_req.rf && i_req.addr >= 7'h74
        |=> o_mem_req.rd && !o_mem_req.bank) else $error("system bank bad");
    a_wdt_pulse: assert property (wr_c && ctl_c && i_req.addr == 7'h03 &&
        i_req.wdata[3] |=> o_actions.watchdog_clear_bit)
        else $error("clear pulse missing");
    a_unused_keep: assert property (wr_c && ctl_c &&
        i_req.addr == 7'h00 |=> $stable(o_cf_value)) else $error("unused write");
    a_act_idle: assert property (!wr_c |=> o_actions == '0)
        else $error("stray action pulse");
    a_conv_pulse: assert property (wr_c && ctl_c && i_req.addr == 7'h20
        |=> o_actions.conversion_start_bit == $past(i_req.wdata[0]))
        else $error("start pulse bad");
    a_fwd_write: assert property (wr_c && !ctl_c &&
        !(!i_req.bank && i_req.addr inside {7'h70, 7'h71}) |=>
        o_mem_req.wr && o_mem_req.addr == $past(i_req.addr) &&
        o_mem_req.wdata == $past(i_req.wdata)) else $error("write not forwarded");
endmodule // nibble_gpio_ports_sva
bind nibble_gpio_ports nibble_gpio_ports_sva u_sva (.i_mclk(i_mclk),
    .i_rst(i_rst), .i_req(i_req), .i_pa_pins(i_pa_pins), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .o_mem_req(o_mem_req), .o_pa_out(o_pa_out),
    .o_pa_oe_n(o_pa_oe_n), .o_pb_oe_n(o_pb_oe_n), .o_pa_pullup(o_pa_pullup),
    .o_pb_pullup(o_pb_pullup), .o_cf_value(o_cf_value),
    .o_actions(o_actions));
`default_nettype wire

// ==== dv/nibble_gpio_ports_tb_top.sv ====
// Self-checking bench for the nibble port block.
`timescale 1ns/10ps
`default_nettype none
module nibble_gpio_ports_tb_top;
    import nibble_gpio_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    cpu_req_s req = '0;
    nibble_t mem_rd = 4'h0;
    nibble_t ext_a = 4'h0;
    nibble_t ext_b = 4'h0;
    logic ext_en = 1'b1;
    // Slot 21H is made read-only so that the status read path is exercised.
    localparam cf_file_t RO_SET = {{30{4'h0}}, 4'hf, {33{4'h0}}};
    cf_file_t cf_st = '0;
    nibble_t pa_pins, pb_pins, rdata, pa_out, pa_oe_n, pb_out, pb_oe_n;
    logic rvalid, pa_pull, pb_pull;
    int err_count = 0;
    int cmp_count = 0;
    addr_t act[5] = '{7'h03, 7'h11, 7'h12, 7'h13, 7'h20};
    always #20 i_mclk = ~i_mclk;
    nibble_gpio_ports #(.RO_MASKS(RO_SET)) dut (.i_mclk(i_mclk),
        .i_rst(i_rst), .i_req(req),
        .i_mem_rdata(mem_rd), .i_cf_status(cf_st), .i_pa_pins(pa_pins),
        .i_pb_pins(pb_pins), .o_rdata(rdata), .o_rvalid(rvalid),
        .o_mem_req(), .o_pa_out(pa_out), .o_pa_oe_n(pa_oe_n),
        .o_pa_pullup(pa_pull), .o_pb_out(pb_out), .o_pb_oe_n(pb_oe_n),
        .o_pb_pullup(pb_pull), .o_cf_value(), .o_actions());
    pin_side_model pa_side (.i_mclk(i_mclk), .i_out(pa_out), .i_oe_n(pa_oe_n),
        .i_pullup(pa_pull), .i_ext_en(ext_en), .i_ext(ext_a), .o_pins(pa_pins));
    pin_side_model pb_side (.i_mclk(i_mclk), .i_out(pb_out), .i_oe_n(pb_oe_n),
        .i_pullup(pb_pull), .i_ext_en(ext_en), .i_ext(ext_b), .o_pins(pb_pins));
    function automatic nibble_t pin_exp(input logic dir, pu,
                                        input nibble_t lat, ext);
        return dir ? lat : (pu ? 4'hf : ext);
    endfunction
    task automatic chk(input nibble_t got, input nibble_t exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic put(input logic rf, bk, input addr_t a, input nibble_t d);
        @(posedge i_mclk);
        req <= {1'b0, 1'b1, rf, bk, a, d};
        @(posedge i_mclk);
        req <= '0;
        @(posedge i_mclk);
    endtask
    task automatic get(input logic rf, bk, input addr_t a, input nibble_t e);
        @(posedge i_mclk);
        req <= {1'b1, 1'b0, rf, bk, a, 4'h0};
        @(posedge i_mclk);
        req <= '0;
        @(posedge i_mclk);
        #1;
        chk({3'h0, rvalid}, 4'h1);
        chk(rdata, e);
    endtask
    task automatic do_reset();
        @(posedge i_mclk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        #1;
        chk(pa_oe_n & pb_oe_n, 4'hf);
        chk(pa_out | pb_out | {2'h0, pa_pull, pb_pull}, 4'h0);
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // The full sequence needs about five hundred cycles; ten thousand is ample.
    initial begin
        #400000;
        err_count++;
        wrap_up();
    end
    initial begin
        nibble_t d, x;
        logic p;
        void'($urandom(18713));
        do_reset();
        for (int i = 0; i < 24; i++) begin
            d = nibble_t'($urandom);
            x = nibble_t'($urandom);
            p = i[0];
            @(posedge i_mclk);
            ext_a <= x;
            ext_b <= ~x;
            put(i[1], 1'b0, 7'h70 + 7'(p), d);
            get(i[1], 1'b0, 7'h70 + 7'(p), pin_exp(1'b0, 1'b0, d, p ? ~x : x));
            put(1'b1, i[2], 7'h2c, {2'h0, p, ~p});
            @(posedge i_mclk);
            #1;
            chk(p ? pb_oe_n : pa_oe_n, 4'h0);
            chk(p ? pa_oe_n : pb_oe_n, 4'hf);
            chk(p ? pb_out : pa_out, d);
            get(1'b0, 1'b0, 7'h70 + 7'(p), pin_exp(1'b1, 1'b0, d, x));
            put(1'b1, 1'b0, 7'h2c, 4'h0);
        end
        ext_en <= 1'b0;
        put(1'b1, 1'b1, 7'h0c, 4'hf);
        get(1'b1, 1'b0, 7'h0c, 4'h3);
        get(1'b0, 1'b0, 7'h70, pin_exp(1'b0, 1'b1, 4'h0, 4'h0));
        get(1'b0, 1'b0, 7'h71, pin_exp(1'b0, 1'b1, 4'h0, 4'h0));
        put(1'b1, 1'b0, 7'h0c, 4'h0);
        ext_en <= 1'b1;
        foreach (act[k]) begin
            put(1'b1, 1'b0, act[k], 4'hf);
            get(1'b1, 1'b0, act[k], 4'h0);
        end
        put(1'b1, 1'b0, 7'h1b, 4'ha);
        get(1'b1, 1'b1, 7'h1b, 4'ha);
        put(1'b1, 1'b0, 7'h00, 4'hf);
        get(1'b1, 1'b0, 7'h00, 4'h0);
        d = nibble_t'($urandom);
        @(posedge i_mclk);
        mem_rd <= d;
        cf_st[6'h21] <= d;
        put(1'b1, 1'b0, 7'h21, ~d);
        get(1'b1, 1'b1, 7'h21, d);
        put(1'b1, 1'b1, 7'h45, ~d);
        get(1'b1, 1'b1, 7'h70, d);
        get(1'b1, 1'b1, 7'h45, d);
        get(1'b1, 1'b1, 7'h7a, d);
        put(1'b0, 1'b0, 7'h71, 4'h5);
        put(1'b1, 1'b0, 7'h2c, 4'h3);
        do_reset();
        wrap_up();
    end
endmodule // nibble_gpio_ports_tb_top
`default_nettype wire
